// [lmsb_ctrl.v]
// Top of the LED matrix controller: registers, shadowed breath timing, scan and per-dot PWM.
`include "lmsb_regs.vh"

module lmsb_ctrl #(
    parameter SCAN_CYC = `LMSB_SCAN_US * `LMSB_CLK_MHZ,
    parameter BREATH_UNIT_CYC = `LMSB_BREATH_UNIT_US * `LMSB_CLK_MHZ
) (
    input wire core_clk, // System clock, 50 MHz.
    input wire resetn, // Asynchronous reset, active low.
    input wire [1:0] reg_page, // Register page: PWM, mode or function.
    input wire [7:0] reg_addr, // Register offset inside the page.
    input wire [7:0] reg_wdata, // Write data.
    input wire reg_wr, // Write strobe, one cycle.
    input wire reg_rd, // Read strobe, one cycle.
    output reg [7:0] reg_rdata_q, // Read data, valid the cycle after the strobe.
    output reg [11:0] column_switch_sink_n_q, // Column switches, low sinks current.
    output reg [7:0] row_current_source_q, // Row current sources on.
    output reg [7:0] global_current_scale_q, // Current scale for all rows.
    output reg [2:0] column_pullup_code_q, // Column pull-up resistor select.
    output reg [2:0] row_pulldown_code_q, // Row pull-down resistor select.
    output reg breath_enable_q // Global breathing enable.
);

    localparam BLANK_CYC = `LMSB_BLANK_US * `LMSB_CLK_MHZ;
    localparam SUB_CYC = BREATH_UNIT_CYC / `LMSB_PWM_STEPS;

    integer i;

    // Per-dot storage and breath timing storage.
    reg [7:0] pwm_mem [0:`LMSB_DOTS-1];
    reg [1:0] mode_mem [0:`LMSB_DOTS-1];
    reg [7:0] shadow_q [0:`LMSB_TIME_REGS-1];
    reg [7:0] active_q [0:`LMSB_TIME_REGS-1];

    reg [23:0] sub_cnt_q;
    reg sub_tick_q;
    reg restart_q;
    reg ben_prev_q;

    wire [3:0] col;
    wire slot_on;
    wire [7:0] step;
    wire [7:0] level [0:2];
    wire [7:0] duty [0:`LMSB_ROWS-1];

    // Register port decode.
    wire page_func = (reg_page == `LMSB_PAGE_FUNC);
    wire dot_ok = (reg_addr[3] == 1'b0) && (reg_addr[7:4] < `LMSB_COLS);
    wire [6:0] dot_idx = {reg_addr[7:4], 3'b000} + {4'h0, reg_addr[2:0]};
    wire wr_pwm = reg_wr && (reg_page == `LMSB_PAGE_PWM) && dot_ok;
    wire wr_mode = reg_wr && (reg_page == `LMSB_PAGE_MODE) && dot_ok;
    wire wr_time = reg_wr && page_func && (reg_addr >= `LMSB_OFS_TIME_FIRST) && (reg_addr <= `LMSB_OFS_TIME_LAST);
    wire [3:0] time_idx = reg_addr[3:0] - 4'h2;
    wire upd = reg_wr && page_func && (reg_addr == `LMSB_OFS_UPDATE) && (reg_wdata == `LMSB_UPDATE_KEY);
    wire soft_clr = reg_rd && page_func && (reg_addr == `LMSB_OFS_RESET);

    // defaults at power-up
    // Per-dot PWM and mode memories, cleared by reset and by the read-to-reset register.
    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (i = 0; i < `LMSB_DOTS; i = i + 1)
            begin
                pwm_mem[i] <= `LMSB_RST_BYTE;
                mode_mem[i] <= `LMSB_RST_MODE;
            end
        end
        else if (soft_clr)
        begin
            for (i = 0; i < `LMSB_DOTS; i = i + 1)
            begin
                pwm_mem[i] <= `LMSB_RST_BYTE;
                mode_mem[i] <= `LMSB_RST_MODE;
            end
        end
        else
        begin
            if (wr_pwm)
                pwm_mem[dot_idx] <= reg_wdata;
            if (wr_mode)
                mode_mem[dot_idx] <= reg_wdata[1:0];
        end
    end

    // shadow timing writes
    // Shadow timing registers take host writes; active copies change only on the update strobe or a read of the reset register.
    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (i = 0; i < `LMSB_TIME_REGS; i = i + 1)
            begin
                shadow_q[i] <= `LMSB_RST_BYTE;
                active_q[i] <= `LMSB_RST_BYTE;
            end
        end
        else if (soft_clr)
        begin
            for (i = 0; i < `LMSB_TIME_REGS; i = i + 1)
            begin
                shadow_q[i] <= `LMSB_RST_BYTE;
                active_q[i] <= `LMSB_RST_BYTE;
            end
        end
        else
        begin
            if (wr_time)
                shadow_q[time_idx] <= reg_wdata;
            if (upd)
            begin
                for (i = 0; i < `LMSB_TIME_REGS; i = i + 1)
                    active_q[i] <= shadow_q[i];
            end
        end
    end

    // Function page control registers.
    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            breath_enable_q <= 1'b0;
            global_current_scale_q <= `LMSB_RST_BYTE;
            column_pullup_code_q <= `LMSB_RST_CODE;
            row_pulldown_code_q <= `LMSB_RST_CODE;
        end
        else if (soft_clr)
        begin
            breath_enable_q <= 1'b0;
            global_current_scale_q <= `LMSB_RST_BYTE;
            column_pullup_code_q <= `LMSB_RST_CODE;
            row_pulldown_code_q <= `LMSB_RST_CODE;
        end
        else if (reg_wr && page_func)
        begin
            case (reg_addr)
                `LMSB_OFS_CONFIG: breath_enable_q <= reg_wdata[`LMSB_CFG_BEN_BIT];
                `LMSB_OFS_GCC: global_current_scale_q <= reg_wdata;
                `LMSB_OFS_PULLUP: column_pullup_code_q <= reg_wdata[`LMSB_RES_CODE_MSB:0];
                `LMSB_OFS_PULLDOWN: row_pulldown_code_q <= reg_wdata[`LMSB_RES_CODE_MSB:0];
                default: breath_enable_q <= breath_enable_q;
            endcase
        end
    end

    // Read data: timing and update registers are write-only and read as zero.
    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            reg_rdata_q <= 8'h00;
        else if (reg_rd)
        begin
            reg_rdata_q <= 8'h00;
            if (reg_page == `LMSB_PAGE_PWM && dot_ok)
                reg_rdata_q <= pwm_mem[dot_idx];
            else if (reg_page == `LMSB_PAGE_MODE && dot_ok)
                reg_rdata_q <= {6'h00, mode_mem[dot_idx]};
            else if (page_func)
            begin
                case (reg_addr)
                    `LMSB_OFS_CONFIG: reg_rdata_q <= {6'h00, breath_enable_q, 1'b0};
                    `LMSB_OFS_GCC: reg_rdata_q <= global_current_scale_q;
                    `LMSB_OFS_PULLUP: reg_rdata_q <= {5'h00, column_pullup_code_q};
                    `LMSB_OFS_PULLDOWN: reg_rdata_q <= {5'h00, row_pulldown_code_q};
                    default: reg_rdata_q <= 8'h00;
                endcase
            end
        end
    end

    // Breath time base: one tick per 256th of the 0.21 s unit, and restart on enable or update.
    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sub_cnt_q <= 24'h000000;
            sub_tick_q <= 1'b0;
            restart_q <= 1'b0;
            ben_prev_q <= 1'b0;
        end
        else
        begin
            ben_prev_q <= breath_enable_q;
            restart_q <= upd || (breath_enable_q && !ben_prev_q);
            if (sub_cnt_q == SUB_CYC[23:0] - 24'h000001)
            begin
                sub_cnt_q <= 24'h000000;
                sub_tick_q <= 1'b1;
            end
            else
            begin
                sub_cnt_q <= sub_cnt_q + 24'h000001;
                sub_tick_q <= 1'b0;
            end
        end
    end

    lmsb_scan #(
        .SCAN_CYC(SCAN_CYC),
        .BLANK_CYC(BLANK_CYC)
    ) u_scan (
        .core_clk(core_clk),
        .resetn(resetn),
        .col_q(col),
        .slot_on_q(slot_on),
        .step_q(step)
    );

    // Three breathing profiles, each driven by its own four active timing registers.
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : g_prof
            lmsb_breath u_breath (
                .core_clk(core_clk),
                .resetn(resetn),
                .sub_tick(sub_tick_q),
                .restart(restart_q),
                .run(breath_enable_q),
                .rise_code(active_q[4*g][7:5]),
                .hold_code(active_q[4*g][4:1]),
                .fall_code(active_q[4*g+1][7:5]),
                .off_code(active_q[4*g+1][4:1]),
                .end_on(active_q[4*g+2][6]),
                .begin_sel(active_q[4*g+2][5:4]),
                .loop_total({active_q[4*g+2][3:0], active_q[4*g+3]}),
                .level_q(level[g])
            );
        end
    endgenerate

    // Per-row duty for the dot on the current column; breathing scales the PWM value.
    genvar r;
    generate
        for (r = 0; r < `LMSB_ROWS; r = r + 1)
        begin : g_row
            localparam [6:0] ROW_IDX = r;
            wire [6:0] idx = {col, 3'b000} + ROW_IDX;
            wire [1:0] md = mode_mem[idx];
            wire [7:0] pw = pwm_mem[idx];
            wire [7:0] lv = (md == 2'h1) ? level[0] : (md == 2'h2) ? level[1] : level[2];
            wire [15:0] prod = pw * lv;
            assign duty[r] = (md == `LMSB_MODE_PWM || !breath_enable_q) ? pw : prod[15:8];
        end
    endgenerate

    // Output drive: one column low while its slot is on, rows on for duty of 256 steps.
    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            column_switch_sink_n_q <= 12'hfff;
            row_current_source_q <= 8'h00;
        end
        else
        begin
            for (i = 0; i < `LMSB_COLS; i = i + 1)
                column_switch_sink_n_q[i] <= !(slot_on && (col == i));
            for (i = 0; i < `LMSB_ROWS; i = i + 1)
                row_current_source_q[i] <= slot_on && (step < duty[i]);
        end
    end

endmodule

// [lmsb_regs.vh]
// Register offsets, field positions, reset values and timing constants of the LED matrix controller.
`ifndef LMSB_REGS_VH
`define LMSB_REGS_VH

// Register pages.
`define LMSB_PAGE_PWM 2'h1
`define LMSB_PAGE_MODE 2'h2
`define LMSB_PAGE_FUNC 2'h3

// Function page offsets.
`define LMSB_OFS_CONFIG 8'h00
`define LMSB_OFS_GCC 8'h01
`define LMSB_OFS_TIME_FIRST 8'h02
`define LMSB_OFS_TIME_LAST 8'h0d
`define LMSB_OFS_UPDATE 8'h0e
`define LMSB_OFS_PULLUP 8'h0f
`define LMSB_OFS_PULLDOWN 8'h10
`define LMSB_OFS_RESET 8'h11

// Field positions and codes.
`define LMSB_CFG_BEN_BIT 1
`define LMSB_RES_CODE_MSB 2
`define LMSB_UPDATE_KEY 8'h00
`define LMSB_MODE_PWM 2'h0

// Reset values.
`define LMSB_RST_BYTE 8'h00
`define LMSB_RST_CODE 3'h0
`define LMSB_RST_MODE 2'h0

// Matrix size and number of timing registers.
`define LMSB_COLS 12
`define LMSB_ROWS 8
`define LMSB_DOTS 96
`define LMSB_TIME_REGS 12

// Timing: clock rate and times in their own units.
`define LMSB_CLK_MHZ 50
`define LMSB_SCAN_US 128
`define LMSB_BLANK_US 8
`define LMSB_BREATH_UNIT_US 210000
`define LMSB_PWM_STEPS 256

`endif

// [lmsb_scan.v]
// Column scan timer: slot, blanking gap and PWM step counter.
`include "lmsb_regs.vh"

module lmsb_scan #(
    parameter SCAN_CYC = 6400,
    parameter BLANK_CYC = 400
) (
    input wire core_clk, // System clock.
    input wire resetn, // Asynchronous reset, active low.
    output reg [3:0] col_q, // Current column index.
    output reg slot_on_q, // High during the column on time.
    output reg [7:0] step_q // PWM step inside the slot.
);

    localparam STEP_CYC = SCAN_CYC / `LMSB_PWM_STEPS;

    reg [15:0] sub_q;
    reg [15:0] blank_q;

    // Each slot runs 256 PWM steps, then a blank gap, then advances the column.
    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            col_q <= 4'h0;
            slot_on_q <= 1'b1;
            step_q <= 8'h00;
            sub_q <= 16'h0000;
            blank_q <= 16'h0000;
        end
        else if (slot_on_q)
        begin
            if (sub_q == STEP_CYC[15:0] - 16'h0001)
            begin
                sub_q <= 16'h0000;
                step_q <= step_q + 8'h01;
                if (step_q == 8'hff)
                    slot_on_q <= 1'b0;
            end
            else
                sub_q <= sub_q + 16'h0001;
        end
        else
        begin
            if (blank_q == BLANK_CYC[15:0] - 16'h0001)
            begin
                blank_q <= 16'h0000;
                slot_on_q <= 1'b1;
                col_q <= (col_q == `LMSB_COLS - 1) ? 4'h0 : col_q + 4'h1;
            end
            else
                blank_q <= blank_q + 16'h0001;
        end
    end

endmodule

// [lmsb_breath.v]
// One automatic breathing profile: rise, hold, fall and off phases with loop counting.
`include "lmsb_regs.vh"

module lmsb_breath (
    input wire core_clk, // System clock.
    input wire resetn, // Asynchronous reset, active low.
    input wire sub_tick, // One 256th of a breathing time unit.
    input wire restart, // Restart the loop at its begin phase.
    input wire run, // Breathing enabled.
    input wire [2:0] rise_code, // Rise time code.
    input wire [3:0] hold_code, // Hold-on time code.
    input wire [2:0] fall_code, // Fall time code.
    input wire [3:0] off_code, // Off time code.
    input wire end_on, // Loop ends in the on state.
    input wire [1:0] begin_sel, // Phase the loop begins in.
    input wire [11:0] loop_total, // Loop count, zero is endless.
    output reg [7:0] level_q // Brightness level of the profile.
);

    localparam S_RISE = 5'b00001;
    localparam S_HOLD = 5'b00010;
    localparam S_FALL = 5'b00100;
    localparam S_OFF = 5'b01000;
    localparam S_STOP = 5'b10000;

    reg [4:0] state_q;
    reg [18:0] cnt_q;
    reg [11:0] loops_q;
    reg extra_q;
    reg stop_on_q;
    reg [3:0] ex;
    reg zero_dur;
    reg [4:0] begin_state;
    wire [18:0] dur;
    wire [18:0] shifted;
    wire last_loop;

    // Phase length in sub ticks is 256 times a power of two; zero codes skip hold and off.
    always @*
    begin
        ex = 4'h0;
        zero_dur = 1'b0;
        case (state_q)
            S_RISE: ex = {1'b0, rise_code};
            S_FALL: ex = {1'b0, fall_code};
            S_HOLD:
            begin
                zero_dur = (hold_code == 4'h0);
                ex = (hold_code > 4'h8) ? 4'h7 : hold_code - 4'h1;
            end
            S_OFF:
            begin
                zero_dur = (off_code == 4'h0);
                ex = (off_code > 4'ha) ? 4'h9 : off_code - 4'h1;
            end
            default: ex = 4'h0;
        endcase
        case (begin_sel)
            2'h0: begin_state = S_RISE;
            2'h1: begin_state = S_HOLD;
            2'h2: begin_state = S_FALL;
            default: begin_state = S_OFF;
        endcase
    end

    assign dur = 19'h00100 << ex;
    assign shifted = cnt_q >> ex;
    assign last_loop = (loop_total != 12'h000) && (loops_q + 12'h001 == loop_total);

    // Phase sequencing and loop counting; a loop is counted at the end of each fall.
    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q <= S_RISE;
            cnt_q <= 19'h00000;
            loops_q <= 12'h000;
            extra_q <= 1'b0;
            stop_on_q <= 1'b0;
        end
        else if (restart || !run)
        begin
            state_q <= begin_state;
            cnt_q <= 19'h00000;
            loops_q <= 12'h000;
            extra_q <= 1'b0;
            stop_on_q <= 1'b0;
        end
        else if (state_q != S_STOP && (zero_dur || (sub_tick && cnt_q == dur - 19'h00001)))
        begin
            cnt_q <= 19'h00000;
            case (state_q)
                S_RISE:
                begin
                    state_q <= extra_q ? S_STOP : S_HOLD;
                    stop_on_q <= extra_q;
                end
                S_HOLD: state_q <= S_FALL;
                S_FALL:
                begin
                    loops_q <= loops_q + 12'h001;
                    if (last_loop && !end_on)
                        state_q <= S_STOP;
                    else
                        state_q <= S_OFF;
                    if (last_loop && end_on)
                        extra_q <= 1'b1;
                end
                S_OFF: state_q <= S_RISE;
                default: state_q <= S_STOP;
            endcase
        end
        else if (sub_tick && state_q != S_STOP)
            cnt_q <= cnt_q + 19'h00001;
    end

    // Output level follows the phase: ramps in rise and fall.
    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            level_q <= 8'h00;
        else if (!run)
            level_q <= 8'h00;
        else
        begin
            case (state_q)
                S_RISE: level_q <= shifted[7:0];
                S_HOLD: level_q <= 8'hff;
                S_FALL: level_q <= 8'hff - shifted[7:0];
                S_OFF: level_q <= 8'h00;
                default: level_q <= stop_on_q ? 8'hff : 8'h00;
            endcase
        end
    end

endmodule

// [lmsb_ctrl_monitor.sv]
// Checker of the LED matrix controller ports: scan timing and register effects.
`include "lmsb_regs.vh"

module lmsb_ctrl_monitor #(
    parameter SCAN_CYC = 512,
    parameter BREATH_UNIT_CYC = 2560
) (
    input wire core_clk, // System clock.
    input wire resetn, // Reset, active low.
    input wire [1:0] reg_page, // Page.
    input wire [7:0] reg_addr, // Offset.
    input wire [7:0] reg_wdata, // Write data.
    input wire reg_wr, // Write strobe.
    input wire reg_rd, // Read strobe.
    input wire [7:0] reg_rdata_q, // Read data.
    input wire [11:0] column_switch_sink_n_q, // Columns.
    input wire [7:0] row_current_source_q, // Rows.
    input wire [7:0] global_current_scale_q, // Scale.
    input wire [2:0] column_pullup_code_q, // Pull-up code.
    input wire [2:0] row_pulldown_code_q, // Pull-down code.
    input wire breath_enable_q // Breath enable.
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam BLANK_CYC = 400;
    wire blank = &column_switch_sink_n_q;
    wire fn = reg_page == `LMSB_PAGE_FUNC;
    reg [15:0] low_cnt_q;
    reg [15:0] hi_cnt_q;
    reg [11:0] last_n_q;
    reg seen_q;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);

    // Measures slot and gap lengths and remembers the last active column.
    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            low_cnt_q <= 16'h0000;
            hi_cnt_q <= 16'h0000;
            last_n_q <= 12'hfff;
            seen_q <= 1'b0;
        end
        else
        begin
            low_cnt_q <= blank ? 16'h0000 : low_cnt_q + 16'h0001;
            hi_cnt_q <= blank ? hi_cnt_q + 16'h0001 : 16'h0000;
            if (!blank)
                last_n_q <= column_switch_sink_n_q;
            if (blank && low_cnt_q != 16'h0000)
                seen_q <= 1'b1;
        end
    end

    slot_length_a: assert property (blank && low_cnt_q != 16'h0000 |-> low_cnt_q == SCAN_CYC)
        else $error("column slot has wrong length");
    blank_length_a: assert property (!blank && hi_cnt_q != 16'h0000 && seen_q |-> hi_cnt_q == BLANK_CYC)
        else $error("blanking gap has wrong length");
    blank_rows_a: assert property (blank |-> row_current_source_q == 8'h00)
        else $error("row driven during blanking");
    column_order_a: assert property (!blank && $past(blank) && seen_q |->
        column_switch_sink_n_q == {last_n_q[10:0], last_n_q[11]})
        else $error("column order wrong");
    one_column_a: assert property ($countones(~column_switch_sink_n_q) <= 1)
        else $error("more than one column sinking");
    pullup_write_a: assert property (reg_wr && fn && reg_addr == `LMSB_OFS_PULLUP |=>
        column_pullup_code_q == $past(reg_wdata[2:0]))
        else $error("pull-up code not taken");
    pulldown_write_a: assert property (reg_wr && fn && reg_addr == `LMSB_OFS_PULLDOWN |=>
        row_pulldown_code_q == $past(reg_wdata[2:0]))
        else $error("pull-down code not taken");
    scale_write_a: assert property (reg_wr && fn && reg_addr == `LMSB_OFS_GCC |=>
        global_current_scale_q == $past(reg_wdata))
        else $error("current scale not taken");
    enable_write_a: assert property (reg_wr && fn && reg_addr == `LMSB_OFS_CONFIG |=>
        breath_enable_q == $past(reg_wdata[1]))
        else $error("breath enable not taken");
    soft_reset_a: assert property (reg_rd && fn && reg_addr == `LMSB_OFS_RESET |=> reg_rdata_q == 8'h00 &&
        global_current_scale_q == 8'h00 && !breath_enable_q && column_pullup_code_q == 3'h0 &&
        row_pulldown_code_q == 3'h0)
        else $error("reset read left a register set");
    code_read_a: assert property (reg_rd && fn && reg_addr == `LMSB_OFS_PULLDOWN |=>
        reg_rdata_q == {5'h00, $past(row_pulldown_code_q)})
        else $error("pull-down readback wrong");
endmodule

// [lmsb_host_model.sv]
// Host model: drives the register port with one-cycle write and read strobes.
`include "lmsb_regs.vh"

module lmsb_host_model (
    input wire core_clk, // System clock.
    output logic [1:0] reg_page, // Page.
    output logic [7:0] reg_addr, // Offset.
    output logic [7:0] reg_wdata, // Write data.
    output logic reg_wr, // Write strobe.
    output logic reg_rd, // Read strobe.
    input wire [7:0] reg_rdata_q // Read data.
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle port at time zero.
    initial
    begin
        reg_page = 2'h0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // One strobe cycle; released lines then change so stale values are never mistaken for live ones.
    task automatic access(input logic [1:0] page, input logic [7:0] addr, input logic [7:0] data, input logic rd);
        @(posedge core_clk);
        #1;
        reg_page = page;
        reg_addr = addr;
        reg_wdata = data;
        reg_wr = !rd;
        reg_rd = rd;
        @(posedge core_clk);
        #1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_page = ~reg_page;
        reg_addr = ~reg_addr;
        reg_wdata = ~reg_wdata;
    endtask

    task automatic write_reg(input logic [1:0] page, input logic [7:0] addr, input logic [7:0] data);
        access(page, addr, data, 1'b0);
    endtask

    task automatic read_reg(input logic [1:0] page, input logic [7:0] addr, output logic [7:0] data);
        access(page, addr, 8'h00, 1'b1);
        data = reg_rdata_q;
    endtask

    task automatic start_breath();
        write_reg(`LMSB_PAGE_FUNC, `LMSB_OFS_CONFIG, 8'h02);
        write_reg(`LMSB_PAGE_FUNC, `LMSB_OFS_UPDATE, `LMSB_UPDATE_KEY);
    endtask
endmodule

// [tb_top.sv]
// Testbench: register accesses and column scan measurements of the LED matrix controller.
`include "lmsb_regs.vh"

module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam SCAN = 512;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    wire [1:0] reg_page;
    wire [7:0] reg_addr;
    wire [7:0] reg_wdata;
    wire reg_wr;
    wire reg_rd;
    wire [7:0] reg_rdata_q;
    wire [11:0] column_switch_sink_n_q;
    wire [7:0] row_current_source_q;
    wire [7:0] global_current_scale_q;
    wire [2:0] column_pullup_code_q;
    wire [2:0] row_pulldown_code_q;
    wire breath_enable_q;
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int on_cnt [4];
    logic [7:0] rd;
    logic [7:0] tm_addr [6] = '{8'h02, 8'h04, 8'h06, 8'h08, 8'h0b, 8'h0c};
    logic [7:0] tm_data [6] = '{8'h10, 8'h10, 8'h10, 8'h10, 8'h10, 8'h30};

    lmsb_ctrl #(.SCAN_CYC(SCAN), .BREATH_UNIT_CYC(2560)) i_dut (
        .core_clk(core_clk), .resetn(resetn), .reg_page(reg_page), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .column_switch_sink_n_q(column_switch_sink_n_q), .row_current_source_q(row_current_source_q),
        .global_current_scale_q(global_current_scale_q), .column_pullup_code_q(column_pullup_code_q),
        .row_pulldown_code_q(row_pulldown_code_q), .breath_enable_q(breath_enable_q));

    lmsb_host_model i_host (
        .core_clk(core_clk), .reg_page(reg_page), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q));

    // Clock of 20 ns period.
    initial
    begin
        forever #10 core_clk = ~core_clk;
    end

    // Ends a hung run.
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 90000)
        begin
            fail_count++;
            results();
        end
    end

    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        if (fail_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Counts on cycles of rows 0 to 3 over one whole slot of column 0 and compares with duty times two.
    task automatic expect_rows(input int e[4]);
        for (int r = 0; r < 4; r++)
            on_cnt[r] = 0;
        while (column_switch_sink_n_q[0] !== 1'b1)
            @(posedge core_clk);
        while (column_switch_sink_n_q[0] !== 1'b0)
            @(posedge core_clk);
        while (column_switch_sink_n_q[0] === 1'b0)
        begin
            for (int r = 0; r < 4; r++)
                on_cnt[r] += row_current_source_q[r];
            @(posedge core_clk);
        end
        for (int r = 0; r < 4; r++)
            check(on_cnt[r][11:0], e[r][11:0]);
    endtask

    // Main sequence.
    initial
    begin
        repeat (4) @(posedge core_clk);
        #1;
        resetn = 1'b1;
        @(posedge core_clk);
        #1;
        check({breath_enable_q, column_pullup_code_q, row_pulldown_code_q}, 7'h00);
        check(global_current_scale_q, 8'h00);
        for (int k = 0; k < 8; k++)
        begin
            i_host.write_reg(`LMSB_PAGE_FUNC, `LMSB_OFS_PULLUP, {5'h1f, k[2:0]});
            i_host.write_reg(`LMSB_PAGE_FUNC, `LMSB_OFS_PULLDOWN, {5'h15, ~k[2:0]});
            check(column_pullup_code_q, k[2:0]);
            check(row_pulldown_code_q, 3'(~k[2:0]));
            i_host.read_reg(`LMSB_PAGE_FUNC, `LMSB_OFS_PULLUP, rd);
            check(rd, {5'h00, k[2:0]});
            i_host.read_reg(`LMSB_PAGE_FUNC, `LMSB_OFS_PULLDOWN, rd);
            check(rd, {5'h00, ~k[2:0]});
        end
        i_host.write_reg(`LMSB_PAGE_FUNC, `LMSB_OFS_GCC, 8'ha5);
        check(global_current_scale_q, 8'ha5);
        i_host.write_reg(`LMSB_PAGE_FUNC, `LMSB_OFS_CONFIG, 8'h02);
        i_host.read_reg(`LMSB_PAGE_FUNC, `LMSB_OFS_CONFIG, rd);
        check({breath_enable_q, rd}, 9'h102);
        i_host.write_reg(`LMSB_PAGE_FUNC, `LMSB_OFS_CONFIG, 8'hfd);
        i_host.read_reg(`LMSB_PAGE_FUNC, `LMSB_OFS_CONFIG, rd);
        check({breath_enable_q, rd}, 9'h000);
        // Dots 0..3 of column 0 get modes 1, 2, 3, 0.
        for (int r = 0; r < 4; r++)
        begin
            i_host.write_reg(`LMSB_PAGE_PWM, r[7:0], (r == 1) ? 8'h04 : 8'h80);
            i_host.write_reg(`LMSB_PAGE_MODE, r[7:0], {6'h00, r[1:0] + 2'h1});
        end
        expect_rows('{256, 8, 256, 256});
        for (int i = 0; i < 6; i++)
            i_host.write_reg(`LMSB_PAGE_FUNC, tm_addr[i], tm_data[i]);
        i_host.start_breath();
        expect_rows('{254, 6, 0, 256});
        i_host.write_reg(`LMSB_PAGE_FUNC, 8'h03, 8'h10);
        i_host.write_reg(`LMSB_PAGE_FUNC, 8'h04, 8'h30);
        i_host.write_reg(`LMSB_PAGE_FUNC, `LMSB_OFS_CONFIG, 8'h00);
        i_host.write_reg(`LMSB_PAGE_FUNC, `LMSB_OFS_CONFIG, 8'h02);
        i_host.write_reg(`LMSB_PAGE_FUNC, `LMSB_OFS_UPDATE, 8'h5a);
        expect_rows('{254, 6, 0, 256});
        i_host.write_reg(`LMSB_PAGE_FUNC, `LMSB_OFS_UPDATE, 8'h00);
        expect_rows('{0, 6, 0, 256});
        i_host.write_reg(`LMSB_PAGE_FUNC, `LMSB_OFS_CONFIG, 8'h00);
        expect_rows('{256, 8, 256, 256});
        i_host.write_reg(`LMSB_PAGE_FUNC, `LMSB_OFS_PULLUP, 8'h05);
        i_host.read_reg(`LMSB_PAGE_FUNC, `LMSB_OFS_RESET, rd);
        check(rd, 8'h00);
        check({global_current_scale_q, 1'b0, column_pullup_code_q}, 12'h000);
        expect_rows('{0, 0, 0, 0});
        results();
    end
endmodule

bind lmsb_ctrl lmsb_ctrl_monitor #(.SCAN_CYC(SCAN_CYC), .BREATH_UNIT_CYC(BREATH_UNIT_CYC)) i_mon (
    .core_clk(core_clk), .resetn(resetn), .reg_page(reg_page), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .column_switch_sink_n_q(column_switch_sink_n_q), .row_current_source_q(row_current_source_q),
    .global_current_scale_q(global_current_scale_q), .column_pullup_code_q(column_pullup_code_q),
    .row_pulldown_code_q(row_pulldown_code_q), .breath_enable_q(breath_enable_q));
